//--- mgmt_master.sv
`timescale 1ns/1ps
module mgmt_master (
  input  wire logic        i_clk,
  output logic      [4:0]  o_addr,
  output logic      [15:0] o_wdata,
  output logic             o_wr,
  output logic             o_rd
);
  initial begin
    o_addr = 5'h00;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // each call holds its strobe through one edge; the next call changes it
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    o_rd <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [4:0] a);
    o_addr <= a;
    o_wr <= 1'b0;
    o_rd <= 1'b1;
    @(posedge i_clk);
  endtask
  task automatic idle;
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    @(posedge i_clk);
  endtask
  // strap override word with reserved bits at defaults, factory bit cleared
  task automatic leave_factory;
    wr(5'h16, 16'h0001);
  endtask
endmodule

//--- phy_vendor_defines.svh
`ifndef PHY_VENDOR_DEFINES_SVH
`define PHY_VENDOR_DEFINES_SVH

// register offsets on the management port
`define OFS_PARTNER_MSG       5'h08
`define OFS_DIGITAL_CTRL      5'h10
`define OFS_AFE_CTRL          5'h11
`define OFS_SYMERR_COUNT      5'h15
`define OFS_STRAP_OVERRIDE    5'h16
`define OFS_EXPANDED_CTRL     5'h18
`define OFS_IRQ_STATUS        5'h1C
`define OFS_IRQ_MASK          5'h1D

// field positions
`define BIT_PLL_OFF           4
`define BIT_SLOW_OSC          5
`define BIT_FACTORY_MODE      15
`define BIT_ENERGY_DETECT_POWERDOWN_DISABLE      11
`define MSG_WIDTH             11
`define IRQ_WIDTH             3
`define IRQ_BIT_SYMERR        0
`define IRQ_BIT_SATURATE      1
`define IRQ_BIT_ENERGY_DETECT_POWERDOWN_ENTRY    2

// reset values
`define RST_PARTNER_MSG       11'h000
`define RST_DIGITAL_CTRL      16'h0000
`define RST_AFE_CTRL          16'h0000
`define RST_SYMERR_COUNT      16'h0000
`define RST_STRAP_OVERRIDE    16'h0001
`define RST_EXPANDED_CTRL     16'h0800
`define RST_IRQ               3'h0
`define COUNT_MAX             16'hFFFF

`endif

//--- phy_vendor_pkg.sv
package phy_vendor_pkg;
  typedef logic [15:0] word_t;
  typedef logic [4:0]  addr_t;
  typedef logic [2:0]  irq_t;
endpackage

//--- phy_vendor_regs.sv
// Functional notes
// - Partner next-page message is an 11-bit read-only field, bits 10:0, reset zero.
// - PLL-off bit set: PLL switched off while in energy-detect power-down.
// - PLL-off bit clear (reset): PLL keeps running in energy-detect power-down.
// - Slow-oscillator bit set: crystal input dropped, internal slow oscillator used.
// - Slow-oscillator mode also powers down the analog front end.
// - 16-bit symbol-error frame counter, reset zero, cleared by its read.
// - Factory-mode bit 0 is normal operation, 1 is factory test mode.
// - Factory-mode bit loaded from the transmit-clock strap at reset release.
// - Energy-detect power-down enabled when its bit is 0; reset value is 1.
`timescale 1ns/1ps
`include "phy_vendor_defines.svh"
module phy_vendor_regs (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  input  wire logic [4:0]             i_addr,
  input  wire logic [15:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  input  wire logic [10:0]            i_partner_msg,
  input  wire logic                   i_no_energy,
  input  wire logic                   i_symerr_frame,
  input  wire logic                   i_strap_txc,
  output logic      [15:0]            o_rdata,
  output logic                        o_pll_off,
  output logic                        o_slow_osc_sel,
  output logic                        o_analog_frontend_powerdown,
  output logic                        o_energy_detect_powerdown,
  output logic                        o_factory_mode,
  output logic                        o_irq
);

  phy_vendor_pkg::word_t digital_reserved_control;
  phy_vendor_pkg::word_t analog_frontend_control_one;
  phy_vendor_pkg::word_t strap_override_control;
  phy_vendor_pkg::word_t expanded_control;
  phy_vendor_pkg::irq_t  irq_status;
  phy_vendor_pkg::irq_t  irq_mask;
  phy_vendor_pkg::irq_t  irq_event;
  logic [10:0]           partner_next_page_msg;
  logic                  strap_taken;
  logic                  energy_detect_powerdown_active;
  logic                  energy_detect_powerdown_prev;
  logic                  wr_digital;
  logic                  wr_afe;
  logic                  wr_strap;
  logic                  wr_expanded;
  logic                  wr_status;
  logic                  wr_mask;
  phy_vendor_pkg::word_t next_rdata;

  symerr_count_if cnt_bus ();

  symerr_counter u_symerr_counter (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .cnt     (cnt_bus.counter)
  );

  // write decode
  always_comb begin
    wr_digital  = 1'b0;
    wr_afe      = 1'b0;
    wr_strap    = 1'b0;
    wr_expanded = 1'b0;
    wr_status   = 1'b0;
    wr_mask     = 1'b0;
    if (i_wr) begin
      if (i_addr == `OFS_DIGITAL_CTRL) begin
        wr_digital = 1'b1;
      end else if (i_addr == `OFS_AFE_CTRL) begin
        wr_afe = 1'b1;
      end else if (i_addr == `OFS_STRAP_OVERRIDE) begin
        wr_strap = 1'b1;
      end else if (i_addr == `OFS_EXPANDED_CTRL) begin
        wr_expanded = 1'b1;
      end else if (i_addr == `OFS_IRQ_STATUS) begin
        wr_status = 1'b1;
      end else if (i_addr == `OFS_IRQ_MASK) begin
        wr_mask = 1'b1;
      end
    end
  end

  // counter steering: a read of the counter clears it
  assign cnt_bus.inc   = i_symerr_frame;
  assign cnt_bus.clear = i_rd && i_addr == `OFS_SYMERR_COUNT;

  // partner message follows the receive side
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      partner_next_page_msg <= `RST_PARTNER_MSG;
    end else begin
      partner_next_page_msg <= i_partner_msg;
    end
  end

  // reserved bits are plain storage, written back by the controller
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      digital_reserved_control <= `RST_DIGITAL_CTRL;
    end else if (wr_digital) begin
      digital_reserved_control <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      analog_frontend_control_one <= `RST_AFE_CTRL;
    end else if (wr_afe) begin
      analog_frontend_control_one <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      expanded_control <= `RST_EXPANDED_CTRL;
    end else if (wr_expanded) begin
      expanded_control <= i_wdata;
    end
  end

  // strap capture on the first edge after reset release
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_taken <= 1'b0;
    end else begin
      strap_taken <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_override_control <= `RST_STRAP_OVERRIDE;
    end else if (!strap_taken) begin
      strap_override_control[`BIT_FACTORY_MODE] <= i_strap_txc;
    end else if (wr_strap) begin
      strap_override_control <= i_wdata;
    end
  end

  // energy-detect power-down state
  assign energy_detect_powerdown_active = !expanded_control[`BIT_ENERGY_DETECT_POWERDOWN_DISABLE] && i_no_energy;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      energy_detect_powerdown_prev <= 1'b0;
    end else begin
      energy_detect_powerdown_prev <= energy_detect_powerdown_active;
    end
  end

  // device controls
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_energy_detect_powerdown <= 1'b0;
      o_pll_off                 <= 1'b0;
    end else begin
      o_energy_detect_powerdown <= energy_detect_powerdown_active;
      o_pll_off <= energy_detect_powerdown_active && digital_reserved_control[`BIT_PLL_OFF];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_slow_osc_sel              <= 1'b0;
      o_analog_frontend_powerdown <= 1'b0;
    end else begin
      o_slow_osc_sel              <= analog_frontend_control_one[`BIT_SLOW_OSC];
      o_analog_frontend_powerdown <= analog_frontend_control_one[`BIT_SLOW_OSC];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_factory_mode <= 1'b0;
    end else begin
      o_factory_mode <= strap_override_control[`BIT_FACTORY_MODE];
    end
  end

  // interrupt events
  always_comb begin
    irq_event                      = `RST_IRQ;
    irq_event[`IRQ_BIT_SYMERR]     = i_symerr_frame;
    irq_event[`IRQ_BIT_SATURATE]   = cnt_bus.saturated;
    irq_event[`IRQ_BIT_ENERGY_DETECT_POWERDOWN_ENTRY] = energy_detect_powerdown_active && !energy_detect_powerdown_prev;
  end

  // sticky status, write one to clear, new event wins
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_status <= `RST_IRQ;
    end else if (wr_status) begin
      irq_status <= (irq_status & ~i_wdata[`IRQ_WIDTH-1:0]) | irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_mask <= `RST_IRQ;
    end else if (wr_mask) begin
      irq_mask <= i_wdata[`IRQ_WIDTH-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_status & irq_mask);
    end
  end

  // read decode
  always_comb begin
    next_rdata = 16'h0000;
    if (i_addr == `OFS_PARTNER_MSG) begin
      next_rdata[`MSG_WIDTH-1:0] = partner_next_page_msg;
    end else if (i_addr == `OFS_DIGITAL_CTRL) begin
      next_rdata = digital_reserved_control;
    end else if (i_addr == `OFS_AFE_CTRL) begin
      next_rdata = analog_frontend_control_one;
    end else if (i_addr == `OFS_SYMERR_COUNT) begin
      next_rdata = cnt_bus.count;
    end else if (i_addr == `OFS_STRAP_OVERRIDE) begin
      next_rdata = strap_override_control;
    end else if (i_addr == `OFS_EXPANDED_CTRL) begin
      next_rdata = expanded_control;
    end else if (i_addr == `OFS_IRQ_STATUS) begin
      next_rdata[`IRQ_WIDTH-1:0] = irq_status;
    end else if (i_addr == `OFS_IRQ_MASK) begin
      next_rdata[`IRQ_WIDTH-1:0] = irq_mask;
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= 16'h0000;
    end
  end

endmodule

//--- phy_vendor_regs_props.sv
`timescale 1ns/1ps
module phy_vendor_regs_props (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [4:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [10:0] i_partner_msg,
  input wire logic        i_no_energy,
  input wire logic        i_symerr_frame,
  input wire logic        i_strap_txc,
  input wire logic [15:0] o_rdata,
  input wire logic        o_pll_off,
  input wire logic        o_slow_osc_sel,
  input wire logic        o_analog_frontend_powerdown,
  input wire logic        o_energy_detect_powerdown,
  input wire logic        o_factory_mode,
  input wire logic        o_irq
);
  logic [1:0] n;
  // edges seen since reset release
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) n <= 2'h0;
    else if (n != 2'h3) n <= n + 2'h1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_msg_upper;
    i_rd && i_addr == 5'h08 |=> o_rdata[15:11] == 5'h00;
  endproperty
  a_msg_upper: assert property (p_msg_upper) else $error("msg upper bits set");
  property p_pll_keep;
    (i_wr && i_addr == 5'h10 && !i_wdata[4]) ##1 !(i_wr && i_addr == 5'h10) |-> ##1 !o_pll_off;
  endproperty
  a_pll_keep: assert property (p_pll_keep) else $error("pll off while bit clear");
  property p_pd_off;
    (i_wr && i_addr == 5'h18 && i_wdata[11]) ##1 !(i_wr && i_addr == 5'h18)
      |-> ##1 !o_energy_detect_powerdown && !o_pll_off;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("power-down while disabled");
  property p_osc;
    (i_wr && i_addr == 5'h11) ##1 !(i_wr && i_addr == 5'h11)
      |-> ##1 o_slow_osc_sel == $past(i_wdata[5], 2);
  endproperty
  a_osc: assert property (p_osc) else $error("slow osc select wrong");
  property p_afe;
    o_analog_frontend_powerdown == o_slow_osc_sel;
  endproperty
  a_afe: assert property (p_afe) else $error("analog power-down mismatch");
  property p_factory;
    (n != 2'h0 && i_wr && i_addr == 5'h16) ##1 !(i_wr && i_addr == 5'h16)
      |-> ##1 o_factory_mode == $past(i_wdata[15], 2);
  endproperty
  a_factory: assert property (p_factory) else $error("factory mode wrong");
  property p_strap;
    n == 2'h2 |-> o_factory_mode == $past(i_strap_txc, 2);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not loaded");
  property p_count_clear;
    (i_rd && i_addr == 5'h15 && !i_symerr_frame) ##1 (i_rd && i_addr == 5'h15)
      |-> ##1 o_rdata == 16'h0000;
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("counter not cleared");
  property p_rdata_idle;
    !$past(i_rd) |-> o_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
endmodule
bind phy_vendor_regs phy_vendor_regs_props u_phy_vendor_regs_props (.*);

//--- phy_vendor_regs_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module phy_vendor_regs_tb_top;
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_no_energy = 1'b1;
  logic        i_symerr_frame = 1'b0, i_strap_txc = 1'b1, rd_d = 1'b0;
  logic [10:0] i_partner_msg = 11'h000;
  logic [4:0]  i_addr;
  logic [15:0] i_wdata, o_rdata, e;
  logic        i_wr, i_rd, o_pll_off, o_slow_osc_sel, o_analog_frontend_powerdown;
  logic        o_energy_detect_powerdown, o_factory_mode, o_irq;
  logic [15:0] exp_q[$];
  int          failures = 0, total_checks = 0;
  always #5 i_clk = ~i_clk;
  mgmt_master u_mgmt_master (.i_clk, .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr),
    .o_rd(i_rd));
  phy_vendor_regs u_phy_vendor_regs (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
    .i_partner_msg, .i_no_energy, .i_symerr_frame, .i_strap_txc, .o_rdata, .o_pll_off,
    .o_slow_osc_sel, .o_analog_frontend_powerdown, .o_energy_detect_powerdown,
    .o_factory_mode, .o_irq);
  // read data stand one cycle after the strobe
  always @(posedge i_clk) begin
    if (rd_d) begin
      e = exp_q.pop_front();
      `CHK(o_rdata, e)
    end
    rd_d <= i_rd;
  end
  task automatic rd(input logic [4:0] a, input logic [15:0] v);
    exp_q.push_back(v);
    u_mgmt_master.rd(a);
  endtask
  task automatic settle;
    u_mgmt_master.idle();
    u_mgmt_master.idle();
  endtask
  task automatic wr_settle(input logic [4:0] a, input logic [15:0] d);
    u_mgmt_master.wr(a, d);
    settle();
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    close_out();
  end
  initial begin
    logic [4:0]  ra [9];
    logic [15:0] rv [9];
    logic [10:0] m;
    int          nf;
    ra = '{5'h08, 5'h10, 5'h11, 5'h15, 5'h16, 5'h18, 5'h1c, 5'h1d, 5'h03};
    rv = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8001, 16'h0800, 16'h0000, 16'h0000,
      16'h0000};
    void'($urandom(73479));
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    for (int k = 0; k < 9; k++) rd(ra[k], rv[k]);
    settle();
    `CHK(o_factory_mode, 1'b1)
    u_mgmt_master.leave_factory();
    u_mgmt_master.wr(5'h08, 16'h07ff);
    m = 11'($urandom);
    i_partner_msg <= m;
    settle();
    rd(5'h16, 16'h0001);
    rd(5'h08, {5'h00, m});
    settle();
    `CHK(o_factory_mode, 1'b0)
    wr_settle(5'h10, 16'h0010);
    `CHK({o_energy_detect_powerdown, o_pll_off}, 2'h0)
    wr_settle(5'h18, 16'h0000);
    `CHK({o_energy_detect_powerdown, o_pll_off}, 2'h3)
    wr_settle(5'h10, 16'h0000);
    `CHK({o_energy_detect_powerdown, o_pll_off}, 2'h2)
    wr_settle(5'h11, 16'h0020);
    `CHK({o_slow_osc_sel, o_analog_frontend_powerdown}, 2'h3)
    wr_settle(5'h11, 16'h0000);
    `CHK({o_slow_osc_sel, o_analog_frontend_powerdown}, 2'h0)
    u_mgmt_master.wr(5'h1c, 16'h0007);
    wr_settle(5'h1d, 16'h0001);
    nf = $urandom_range(8, 1);
    repeat (nf) begin
      i_symerr_frame <= 1'b1;
      @(posedge i_clk);
      i_symerr_frame <= 1'b0;
      @(posedge i_clk);
    end
    rd(5'h15, 16'(nf));
    rd(5'h15, 16'h0000);
    rd(5'h1c, 16'h0001);
    settle();
    `CHK(o_irq, 1'b1)
    wr_settle(5'h1d, 16'h0000);
    `CHK(o_irq, 1'b0)
    u_mgmt_master.wr(5'h1d, 16'h0001);
    wr_settle(5'h1c, 16'h0001);
    `CHK(o_irq, 1'b0)
    close_out();
  end
endmodule

//--- symerr_count_if.sv
`timescale 1ns/1ps
interface symerr_count_if;
  logic                 inc;
  logic                 clear;
  logic                 saturated;
  phy_vendor_pkg::word_t count;
  modport owner (output inc, output clear, input count, input saturated);
  modport counter (input inc, input clear, output count, output saturated);
endinterface

//--- symerr_counter.sv
`timescale 1ns/1ps
`include "phy_vendor_defines.svh"
module symerr_counter (
  input  wire logic     i_clk,
  input  wire logic     i_rst_n,
  symerr_count_if.counter cnt
);
  // clear on read; a frame in the same cycle as the clear is kept as one
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt.count <= `RST_SYMERR_COUNT;
    end else if (cnt.clear) begin
      cnt.count <= cnt.inc ? 16'h0001 : `RST_SYMERR_COUNT;
    end else if (cnt.inc && cnt.count != `COUNT_MAX) begin
      cnt.count <= cnt.count + 16'h0001;
    end
  end

  // pulse when the counter reaches its top value
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt.saturated <= 1'b0;
    end else begin
      cnt.saturated <= cnt.inc && !cnt.clear && cnt.count == (`COUNT_MAX - 16'h0001);
    end
  end
endmodule
